// ### core/analog_speed_input_select.sv
/*
 * Analog frequency command selection and combination with an APB register slave.
 * Assumes converted codes of terminals 1, 2, 4 and the terminal 4 enable arrive
 * asynchronously from the front end; range scaling is done there, except the 4-20 mA live zero of terminal 4, removed here.
 */
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "analog_speed_regs.svh"

// Behaviour
// - Select value sets terminal 2 range: 0-5 V, 0-10 V or 0-20 mA; default 1.
// - Terminal 4 range select: 0 default 4-20 mA, 1 is 0-5 V, 2 is 0-10 V.
// - Select values 4, 5, 14, 15 choose override; others choose added compensation.
// - Added modes sum terminal 1 onto the main command from terminal 2 or 4.
// - Override modes take the main command from terminal 1 or 4, never terminal 2.
// - Override factor from terminal 2 spans 50% to 150% of main speed.
// - Without a main command in override mode, the terminal 2 factor is ignored.
// - Terminal 4 counts only while its enable signal is asserted.
// - Gain frequency registers set output at full-scale input, writable anytime.
// - Changing the select value leaves acceleration and deceleration times untouched.
// - Stall level 9999 makes terminal 1 the stall prevention level.
// - Values 10 to 17 allow reversible polarity; below 10 negatives clamp to zero.
module analog_speed_input_select (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [11:0]                term1_code,
	input  wire logic [11:0]                term2_code,
	input  wire logic [11:0]                term4_code,
	input  wire logic                       term4_enable_signal,
	output analog_speed_pkg::sel_mode_t     mode_q,
	output logic      [15:0]                set_freq_q,
	output logic                            reverse_q,
	output logic      [15:0]                stall_level_q
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Codes are assumed to change slowly; a rare torn word lasts one cycle only.
	logic [36:0] pin_meta_q;
	logic [36:0] pin_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {term4_enable_signal, term4_code, term2_code, term1_code};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire logic signed [11:0] t1_s    = pin_sync_q[11:0];
	wire logic        [11:0] t2_code = pin_sync_q[23:12];
	wire logic        [11:0] t4_code = pin_sync_q[35:24];
	wire logic               t4_en   = pin_sync_q[36];

	// ----------------------------------------
	// Parameter registers
	// ----------------------------------------
	logic [4:0]  sel_q;
	logic [1:0]  t4r_q;
	logic [15:0] t2_gain_q;
	logic [15:0] t4_gain_q;
	logic [15:0] stall_q;
	logic [15:0] accel_q;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire logic setup  = psel & ~penable;
	wire logic wr_acc = psel & penable & pready & pwrite;

	wire logic hit_sel   = paddr == `ASI_SEL_OFF;
	wire logic hit_t2g   = paddr == `ASI_T2_GAIN_OFF;
	wire logic hit_t4g   = paddr == `ASI_T4_GAIN_OFF;
	wire logic hit_stall = paddr == `ASI_STALL_OFF;
	wire logic hit_accel = paddr == `ASI_ACCEL_OFF;
	wire logic hit_stat  = paddr == `ASI_STATUS_OFF;
	wire logic hit_freq  = paddr == `ASI_FREQ_OFF;
	wire logic hit_suse  = paddr == `ASI_STALL_USE_OFF;
	wire logic hit_rw    = hit_sel | hit_t2g | hit_t4g | hit_stall | hit_accel;
	wire logic hit_ro    = hit_stat | hit_freq | hit_suse;

	// Select values 8, 9 and above 17 do not exist; ranges above 2 neither
	wire logic [4:0] new_sel = pwdata[`ASI_SEL_MSB:`ASI_SEL_LSB];
	wire logic [1:0] new_t4r = pwdata[`ASI_T4R_MSB:`ASI_T4R_LSB];
	wire logic sel_ok = (new_sel <= `ASI_SEL_LIMIT) && (new_sel != 5'h08) && (new_sel != 5'h09);
	wire logic t4r_ok = new_t4r != 2'h3;

	wire logic bad_wr = pwrite & (hit_ro | (hit_sel & ~(sel_ok & t4r_ok)));
	wire logic err_d  = ~(hit_rw | hit_ro) | bad_wr;

	// A refused select leaves both of its fields as they were
	wire logic wr_sel_reg = wr_acc & hit_sel & sel_ok & t4r_ok;
	wire logic wr_t2g     = wr_acc & hit_t2g;
	wire logic wr_t4g     = wr_acc & hit_t4g;
	wire logic wr_stall   = wr_acc & hit_stall;
	wire logic wr_accel   = wr_acc & hit_accel;
	wire logic rd_ok      = setup & ~pwrite & ~err_d;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Fold 10..17 onto 0..7: the two halves differ only in polarity handling
	wire logic [4:0] digit = (sel_q >= `ASI_REV_FIRST) ? (sel_q - `ASI_REV_FIRST) : sel_q;

	wire logic t2_5v  = (digit == 5'h01) | (digit == 5'h03) | (digit == 5'h05);
	wire logic t2_ma  = (digit == 5'h06) | (digit == 5'h07);
	wire logic t1_10v = (digit == 5'h00) | (digit == 5'h01) | (digit == 5'h04)
	                  | (digit == 5'h06);
	wire logic ovr    = (digit == 5'h04) | (digit == 5'h05);
	wire logic rev_ok = sel_q >= `ASI_REV_FIRST;

	analog_speed_pkg::sel_mode_t mode_d;

	always_comb begin
		mode_d             = '0;
		mode_d.t2_range    = t2_ma ? analog_speed_pkg::t2_0_20ma :
		                     t2_5v ? analog_speed_pkg::t2_0_5v : analog_speed_pkg::t2_0_10v;
		mode_d.t1_range    = t1_10v ? analog_speed_pkg::t1_pm_10v : analog_speed_pkg::t1_pm_5v;
		case (t4r_q)
			2'h1:    mode_d.t4_range = analog_speed_pkg::t4_0_5v;
			2'h2:    mode_d.t4_range = analog_speed_pkg::t4_0_10v;
			default: mode_d.t4_range = analog_speed_pkg::t4_4_20ma;
		endcase
		mode_d.override_on = ovr;
		mode_d.reversible  = rev_ok;
		mode_d.t4_active   = t4_en;
	end

	// ----------------------------------------
	// Input normalisation to 12-bit fractions
	// ----------------------------------------
	// Terminal 1 magnitude doubled to full scale; -2048 clamps to 2047
	wire logic        t1_neg = t1_s[11];
	wire logic [11:0] t1_abs_raw = t1_neg ? 12'(-t1_s) : 12'(t1_s);
	wire logic [11:0] t1_abs = t1_abs_raw[11] ? 12'h7ff : t1_abs_raw;
	wire logic [11:0] t1_frac = {t1_abs[10:0], 1'b0};

	// Live zero of 4-20 mA: remove the 4 mA part and stretch by 5/4
	wire logic [11:0] t4_off = (t4_code > `ASI_T4_ZERO) ? (t4_code - `ASI_T4_ZERO) : 12'h000;
	wire logic [13:0] t4_str = 14'({2'b00, t4_off} + {4'h0, t4_off[11:2]});
	wire logic [11:0] t4_live = (t4_str > 14'({2'b00, `ASI_FULL})) ? `ASI_FULL : t4_str[11:0];
	wire logic [11:0] t4_frac = (t4r_q == 2'h0) ? t4_live : t4_code;

	// ----------------------------------------
	// Added compensation path
	// ----------------------------------------
	// Terminal 4 takes over as main speed; terminal 2 then plays no part
	wire logic [11:0] add_main = t4_en ? t4_frac : t2_code;
	wire logic signed [13:0] t1_comp = t1_neg ? -14'(t1_frac) : 14'(t1_frac);
	wire logic signed [14:0] add_sum = $signed({3'b000, add_main}) + 15'(t1_comp);
	wire logic add_neg = add_sum[14];
	wire logic [14:0] add_abs = add_neg ? 15'(-add_sum) : 15'(add_sum);
	// Negative sum reverses only where polarity may flip, else clamps to zero
	wire logic [14:0] add_mag = (add_neg & ~rev_ok) ? 15'h0000 : add_abs;
	wire logic [12:0] add_cmd = (add_mag > 15'({3'b000, `ASI_FULL})) ? 13'({1'b0, `ASI_FULL})
	                          : add_mag[12:0];
	wire logic add_rev = add_neg & rev_ok & (add_abs != 15'h0000);

	// ----------------------------------------
	// Override path
	// ----------------------------------------
	// Main speed from terminal 4 if enabled, else terminal 1; terminal 2 never
	wire logic [11:0] ovr_t1 = (t1_neg & ~rev_ok) ? 12'h000 : t1_frac;
	wire logic [11:0] ovr_main = t4_en ? t4_frac : ovr_t1;
	wire logic ovr_rev = ~t4_en & t1_neg & rev_ok & (t1_frac != 12'h000);
	wire logic ovr_present = ovr_main != 12'h000;
	// Factor in 1/4096: half plus the terminal 2 fraction gives 50%..150%
	wire logic [12:0] ovr_factor = ovr_present ? (`ASI_HALF + 13'({1'b0, t2_code}))
	                             : `ASI_UNITY;
	// Absent main command makes the factor unity, so terminal 2 has no effect
	wire logic [24:0] ovr_prod = 25'(ovr_main) * 25'(ovr_factor);
	wire logic [12:0] ovr_cmd = ovr_prod[24:12];

	// ----------------------------------------
	// Frequency scaling
	// ----------------------------------------
	wire logic [12:0] cmd = ovr ? ovr_cmd : add_cmd;
	wire logic        rev = ovr ? ovr_rev : add_rev;
	// Terminal 4 gain while terminal 4 is enabled, else terminal 2 gain, scales full-scale input
	wire logic [15:0] gain = t4_en ? t4_gain_q : t2_gain_q;
	wire logic [28:0] freq_prod = 29'(cmd) * 29'(gain);
	// Above 100% with a large gain the product may pass 16 bits: saturate
	wire logic [15:0] freq_d = freq_prod[28] ? 16'hffff : freq_prod[27:12];

	// Terminal 1 magnitude replaces the stored level at the special value
	wire logic [15:0] stall_d = (stall_q == `ASI_STALL_FROM_T1) ? 16'(t1_frac) : stall_q;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Writing the select touches no other register, so ramp slopes keep their values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= `ASI_SEL_RST;
		end else if (wr_sel_reg) begin
			sel_q <= new_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t4r_q <= `ASI_T4R_RST;
		end else if (wr_sel_reg) begin
			t4r_q <= new_t4r;
		end
	end

	// Gain writes need no live command input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t2_gain_q <= `ASI_GAIN_RST;
		end else if (wr_t2g) begin
			t2_gain_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t4_gain_q <= `ASI_GAIN_RST;
		end else if (wr_t4g) begin
			t4_gain_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_q <= `ASI_STALL_RST;
		end else if (wr_stall) begin
			stall_q <= pwdata[15:0];
		end
	end

	// Stored for software only; the ramp logic lives outside this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accel_q <= `ASI_ACCEL_RST;
		end else if (wr_accel) begin
			accel_q <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Mode and reverse flag load on the same edge, so they never disagree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= '0;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reverse_q <= 1'b0;
		end else begin
			reverse_q <= rev;
		end
	end

	// The long multiply ends here, one flip-flop before the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_freq_q <= '0;
		end else begin
			set_freq_q <= freq_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_level_q <= '0;
		end else begin
			stall_level_q <= stall_d;
		end
	end

	// ----------------------------------------
	// APB read and response
	// ----------------------------------------
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = '0;
		if (hit_sel)
			rdata_d = {22'h0, t4r_q, 3'h0, sel_q};
		else if (hit_t2g)
			rdata_d = {16'h0000, t2_gain_q};
		else if (hit_t4g)
			rdata_d = {16'h0000, t4_gain_q};
		else if (hit_stall)
			rdata_d = {16'h0000, stall_q};
		else if (hit_accel)
			rdata_d = {16'h0000, accel_q};
		else if (hit_stat)
			rdata_d = {23'h0, reverse_q, mode_q};
		else if (hit_freq)
			rdata_d = {16'h0000, set_freq_q};
		else if (hit_suse)
			rdata_d = {16'h0000, stall_level_q};
	end

	// Answer is prepared in the setup cycle, so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Error and read data stand only with ready and read as zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup & err_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= rd_ok ? rdata_d : 32'h00000000;
		end
	end

endmodule : analog_speed_input_select

// ### core/analog_speed_regs.svh
/*
 * Register offsets, reset values and fixed counts of the analog speed input select block.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef ANALOG_SPEED_REGS_SVH
`define ANALOG_SPEED_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ASI_SEL_OFF        8'h00
`define ASI_T2_GAIN_OFF    8'h04
`define ASI_T4_GAIN_OFF    8'h08
`define ASI_STALL_OFF      8'h0c
`define ASI_ACCEL_OFF      8'h10
`define ASI_STATUS_OFF     8'h14
`define ASI_FREQ_OFF       8'h18
`define ASI_STALL_USE_OFF  8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASI_SEL_LSB        0
`define ASI_SEL_MSB        4
`define ASI_T4R_LSB        8
`define ASI_T4R_MSB        9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASI_SEL_RST        5'h01
`define ASI_T4R_RST        2'h0
`define ASI_GAIN_RST       16'h1770
`define ASI_STALL_RST      16'h04b0
`define ASI_ACCEL_RST      16'h0032

// ----------------------------------------
// Fixed values
// ----------------------------------------
`define ASI_STALL_FROM_T1  16'h270f
`define ASI_SEL_LIMIT      5'h11
`define ASI_REV_FIRST      5'h0a
`define ASI_T4_ZERO        12'h333
`define ASI_FULL           12'hfff
`define ASI_HALF           13'h0800
`define ASI_UNITY          13'h1000

`endif

// ### core/analog_speed_pkg.sv
/*
 * Types shared by the analog speed input select block.
 * Assumes nothing of its surroundings.
 */
package analog_speed_pkg;

	typedef enum logic [1:0] {
		t2_0_5v,
		t2_0_10v,
		t2_0_20ma
	} t2_range_t;

	typedef enum logic [1:0] {
		t4_4_20ma,
		t4_0_5v,
		t4_0_10v
	} t4_range_t;

	typedef enum logic {
		t1_pm_5v,
		t1_pm_10v
	} t1_range_t;

	// Decoded input configuration, driven to the analog front end
	typedef struct packed {
		t2_range_t t2_range;
		t1_range_t t1_range;
		t4_range_t t4_range;
		logic      override_on;
		logic      reversible;
		logic      t4_active;
	} sel_mode_t;

endpackage : analog_speed_pkg

// ### verif/analog_speed_chk.sv
/*
 * Port checks of the analog speed input select block.
 * Assumes a select write shows on mode_q two edges after its access edge.
 */
`timescale 1ns/1ns
module analog_speed_chk (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   reverse_q,
	input wire logic                   term4_enable_signal,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire analog_speed_pkg::sel_mode_t mode_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_sel;
		psel && penable && pready && pwrite && paddr == 8'h00;
	endsequence
	sequence wr_ok;
		wr_sel ##0 !pslverr;
	endsequence
	sequence wr_bad;
		wr_sel ##0 pslverr;
	endsequence
	AST_T2_RANGE: assert property (wr_ok |-> ##2 mode_q.t2_range ==
		((($past(pwdata[4:0], 2) % 10) > 5) ? 2'h2 : {1'b0, ~$past(pwdata[0], 2)})) else $error("t2 range");
	AST_T4_RANGE: assert property (wr_ok |-> ##2 mode_q.t4_range == $past(pwdata[9:8], 2))
		else $error("t4 range");
	AST_OVERRIDE: assert property (wr_ok |-> ##2 mode_q.override_on ==
		(($past(pwdata[4:0], 2) % 10) inside {4, 5})) else $error("override decode");
	AST_T1_RANGE: assert property (wr_ok |-> ##2 mode_q.t1_range ==
		(($past(pwdata[4:0], 2) % 10) inside {0, 1, 4, 6})) else $error("t1 range");
	AST_REVERSIBLE: assert property (wr_ok |-> ##2 mode_q.reversible == ($past(pwdata[4:0], 2) >= 5'h0a))
		else $error("reversible decode");
	AST_REFUSED_KEPT: assert property (wr_bad |-> ##2 mode_q[7:1] == $past(mode_q[7:1], 2))
		else $error("refused select applied");
	AST_NO_REVERSE: assert property ((!mode_q.reversible)[*2] |-> !reverse_q)
		else $error("reverse while not reversible");
	AST_T4_OFF: assert property ((!term4_enable_signal)[*3] |=> !mode_q.t4_active)
		else $error("t4 active without enable");
	AST_T4_ON: assert property (term4_enable_signal[*4] |-> mode_q.t4_active)
		else $error("t4 inactive with enable");
endmodule : analog_speed_chk

bind analog_speed_input_select analog_speed_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .reverse_q, .term4_enable_signal, .paddr, .pwdata, .mode_q);

// ### verif/analog_src_model.sv
/*
 * Analog command sources and terminal 4 enable, as converted codes.
 * Assumes the bench sets targets; slow mode applies terminal 1, 2 and enable targets every fourth cycle.
 */
`timescale 1ns/1ns
module analog_src_model (
	input  wire logic        pclk,
	input  wire logic        slow,
	input  wire logic        en_set,
	input  wire logic [11:0] t1_set,
	input  wire logic [11:0] t2_set,
	input  wire logic [11:0] t4_set,
	output logic      [11:0] term1_code,
	output logic      [11:0] term2_code,
	output logic      [11:0] term4_code,
	output logic             term4_enable_signal
);
	logic [1:0] lag_q = 2'h0;
	// Ranges follow what software set; no switch model to mismatch
	initial begin
		term1_code = 12'h000;
		term2_code = 12'h000;
		term4_code = 12'h000;
		term4_enable_signal = 1'b0;
	end
	always @(posedge pclk) begin
		lag_q <= lag_q + 2'h1;
		if (!slow || lag_q == 2'h3) begin
			term1_code <= t1_set;
			term2_code <= t2_set;
			term4_enable_signal <= en_set;
		end
		// Terminal 4 carries a value only once enabled; garbage otherwise
		term4_code <= term4_enable_signal ? t4_set : ~term4_code;
	end
endmodule : analog_src_model

// ### verif/analog_speed_input_select_tb_top.sv
/*
 * Self-checking bench of the analog speed input select block.
 * Assumes design, package, checker and source model are compiled before it.
 */
`timescale 1ns/1ns
module analog_speed_input_select_tb_top;
	logic                        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic                        pwrite = 1'b0, slow = 1'b0, en_set = 1'b0;
	logic [7:0]                  paddr = 8'h00;
	logic [31:0]                 pwdata = 32'h0, prdata, rd;
	logic [11:0]                 t1_set = 12'h000, t2_set = 12'h000, t4_set = 12'h000;
	logic                        pready, pslverr, err, reverse_q, term4_enable_signal;
	logic [11:0]                 term1_code, term2_code, term4_code;
	logic [15:0]                 set_freq_q, stall_level_q;
	analog_speed_pkg::sel_mode_t mode_q;
	int                          num_errors = 0, checks_done = 0, s, r, t1, t2, t4;
	bit                          en;
	int                          sels [10] = '{1, 3, 5, 6, 11, 14, 15, 17, 0, 4};
	logic [7:0]                  rst_a [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	logic [31:0]                 rst_v [5] = '{32'h1, 32'h1770, 32'h1770, 32'h4b0, 32'h32};

	analog_speed_input_select i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .term1_code, .term2_code, .term4_code, .term4_enable_signal, .mode_q,
		.set_freq_q, .reverse_q, .stall_level_q);
	analog_src_model i_src (.pclk, .slow, .en_set, .t1_set, .t2_set, .t4_set, .term1_code, .term2_code,
		.term4_code, .term4_enable_signal);

	initial forever #25 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready, read data and error are all taken at the rising edge that ends the access
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			num_errors++;
			$display("unexpected at %0t: no ready on access", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Override scales the main fraction by 50..150 %; added mode sums and clamps
	function automatic logic [31:0] expect_out(int s, bit en, int r, int t1, int t2, int t4);
		int m, v, c;
		logic rev;
		m = 2 * ((t1 < 0) ? -t1 : t1);
		v = (r != 0) ? t4 : ((t4 > 819) ? (t4 - 819) + ((t4 - 819) >> 2) : 0);
		v = (v > 4095) ? 4095 : v;
		rev = 1'b0;
		if ((s % 10) inside {4, 5}) begin
			if (!en) begin
				v = (t1 < 0 && s < 10) ? 0 : m;
				rev = t1 < 0 && s >= 10;
			end
			c = (v * ((v != 0) ? 2048 + t2 : 4096)) >> 12;
		end else begin
			if (!en)
				v = t2;
			v = v + ((t1 < 0) ? -m : m);
			if (v < 0) begin
				rev = s >= 10;
				v = rev ? -v : 0;
			end
			c = (v > 4095) ? 4095 : v;
		end
		return {15'h0, rev, 16'((c * (en ? 2048 : 4096)) >> 12)};
	endfunction : expect_out

	task automatic done(input string name);
		$display("test %s ended: %0d checks", name, checks_done);
	endtask : done

	task automatic results();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	initial begin
		#(50 * 20000);
		num_errors++;
		results();
	end

	initial begin
		void'($urandom(37));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		chk(mode_q, 32'h20, "reset mode");
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, rst_a[i], 32'h0);
			chk(rd, rst_v[i], "reset value");
		end
		done("reset");
		// Last pass writes a bad terminal 4 range with a good select
		for (int i = 0; i < 33; i++) begin
			apb(1'b1, 8'h00, (i == 32) ? 32'h301 : {22'h0, 2'(i % 3), 3'h0, 5'(i)});
			chk(err, (i inside {8, 9} || i > 17), "select refusal");
		end
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h211, "select kept");
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
		apb(1'b1, 8'h14, 32'hff);
		chk(err, 32'h1, "read-only write");
		apb(1'b1, 8'h04, 32'h1000);
		apb(1'b1, 8'h08, 32'h800);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h800, "gain with no command");
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h32, "ramp time");
		done("registers");
		for (int i = 0; i < 40; i++) begin
			s = sels[i % 10];
			en = (i / 10) % 2;
			r = $urandom % 3;
			t1 = (i % 10 == 9) ? -2047 : int'($urandom % 4095) - 2047;
			t2 = $urandom % 4096;
			t4 = (i % 10 == 8) ? 512 : $urandom % 4096;
			apb(1'b1, 8'h00, {22'h0, 2'(r), 3'h0, 5'(s)});
			slow <= $urandom % 2;
			en_set <= en;
			t1_set <= 12'(t1);
			t2_set <= 12'(t2);
			t4_set <= 12'(t4);
			repeat (16) @(posedge pclk);
			chk({reverse_q, set_freq_q}, expect_out(s, en, r, t1, t2, t4), "command");
			chk(mode_q.t4_active, en, "t4 valid");
		end
		done("commands");
		apb(1'b1, 8'h0c, 32'h270f);
		t1_set <= 12'hc18;
		repeat (16) @(posedge pclk);
		chk(stall_level_q, 32'h7d0, "stall from t1");
		apb(1'b1, 8'h0c, 32'h100);
		apb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h100, "stall fixed");
		done("stall");
		results();
	end
endmodule : analog_speed_input_select_tb_top
